// ### inc/host_port_map.svh
`ifndef HOST_PORT_MAP_SVH
`define HOST_PORT_MAP_SVH

// =====================================================================
// Timing figures and encodings.
// CPU clock period in picoseconds.
`define CLK_PERIOD_PS 10000
// Least strobe low width as an absolute time, in picoseconds.
`define STROBE_LOW_ABS_PS 12500
// Least strobe low and high widths counted in CPU periods.
`define STROBE_LOW_PERIODS 4
`define STROBE_HIGH_PERIODS 4
// Strobe low minimum in cycles: the larger of the two figures, rounded up.
`define STROBE_LOW_ABS_CYC ((`STROBE_LOW_ABS_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define STROBE_LOW_CYC ((`STROBE_LOW_ABS_CYC > `STROBE_LOW_PERIODS) ? `STROBE_LOW_ABS_CYC : `STROBE_LOW_PERIODS)
// Access select code that addresses the host data register.
`define SEL_DATA_REG 2'h2
// Host read/write level meaning read.
`define RW_READ 1'b1

`endif

// ### inc/host_port_pkg.sv
// =====================================================================
// Types shared by the host port logic.
package host_port_pkg;

    // Select inputs captured at the start of an access.
    typedef struct packed {
        logic [1:0] access_select;
        logic read_write;
        logic halfword;
    } host_select_t;

    // Access state of the host port.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FETCH = 3'b001,
        ST_READ = 3'b010,
        ST_WRITE = 3'b011,
        ST_WRITE_WAIT = 3'b100,
        ST_DONE = 3'b101
    } port_state_t;

endpackage

// ### rtl/edge_catch.sv
`timescale 1ns/100ps

// =====================================================================
// Registered copy of a level with fall and rise pulses.
module edge_catch (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic enable_i,
    input wire logic level_i,
    output logic level_o,
    output logic fall_o,
    output logic rise_o
);
    logic next_level;

    // Reset to high since every watched host signal idles high.
    always_comb begin
        next_level = level_i;
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            level_o <= 1'b1;
        end else if (enable_i) begin
            level_o <= next_level;
        end
    end

    assign fall_o = level_o & ~level_i;
    assign rise_o = ~level_o & level_i;
endmodule

// ### rtl/host_port_strobe_ready.sv
`timescale 1ns/100ps
`include "host_port_map.svh"
// Function
// RQ1: Internal strobe is chip select OR inverted XOR of the two data strobes.
// RQ2: Access select and read/write qualify accesses; halfword select too in narrow mode.
// RQ3: Data register read requests a fetch at strobe fall; ready stays high until loaded. A narrow-mode read with halfword select high does not fetch here.
// RQ4: Host keeps strobe low until ready goes low, else writes fail.
// RQ5: Address latch strobe is tied high or pulsed once per strobe active period.
// RQ6: Host holds strobe low and high at least four clock periods each.
// RQ7: Selects captured at address latch fall if used, else at strobe fall.
// RQ8: Write data is captured at the strobe rising edge.
// RQ9: Read data drives after strobe falls and floats after strobe rises.
// RQ10: On writes, ready is high while the write buffer cannot accept data.
module host_port_strobe_ready
    import host_port_pkg::*;
#(
    parameter int DATA_W = 32
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic narrow_host_mode_i,
    input wire logic host_chip_select_i,
    input wire logic host_data_strobe_one_i,
    input wire logic host_data_strobe_two_i,
    input wire logic [1:0] host_access_select_i,
    input wire logic host_read_write_i,
    input wire logic halfword_select_i,
    input wire logic host_address_latch_strobe_i,
    input wire logic [DATA_W-1:0] host_data_bus_i,
    output logic [DATA_W-1:0] host_data_bus_o,
    output logic host_data_bus_oe_o,
    output logic host_ready_n_o,
    output logic fetch_req_o,
    input wire logic fetch_load_i,
    input wire logic [DATA_W-1:0] fetch_data_i,
    output logic write_valid_o,
    output logic [DATA_W-1:0] write_data_o,
    output logic write_halfword_o,
    output logic [1:0] write_select_o,
    input wire logic write_buffer_ready_i
);
    // =================================================================
    // Strobe combination and edge detection.
    logic strobe_raw;
    logic strobe_q;
    logic strobe_fall;
    logic strobe_rise;
    logic latch_q;
    logic latch_fall;
    logic latch_rise;

    // Active low: the two strobes differing and chip select low gives zero.
    assign strobe_raw = host_chip_select_i | ~(host_data_strobe_one_i ^ host_data_strobe_two_i); // RQ1

    edge_catch u_strobe_edge (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .enable_i(clk_en_i),
        .level_i(strobe_raw),
        .level_o(strobe_q),
        .fall_o(strobe_fall),
        .rise_o(strobe_rise)
    );

    edge_catch u_latch_edge (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .enable_i(clk_en_i),
        .level_i(host_address_latch_strobe_i),
        .level_o(latch_q),
        .fall_o(latch_fall),
        .rise_o(latch_rise)
    );

    // =================================================================
    // Select capture.
    host_select_t sel_now;
    host_select_t sel;
    host_select_t next_sel;
    logic latched;
    logic next_latched;

    // Halfword select only counts in narrow mode; wide mode forces zero.
    always_comb begin
        sel_now.access_select = host_access_select_i; // RQ2
        sel_now.read_write = host_read_write_i; // RQ2
        sel_now.halfword = narrow_host_mode_i & halfword_select_i; // RQ2
    end

    // A latch strobe fall takes the selects and shields them from the strobe fall that follows.
    // A latch fall in the cycle of a strobe rise belongs to the next access, so the set wins.
    always_comb begin
        next_sel = sel;
        next_latched = latched;
        if (strobe_rise) begin
            next_latched = 1'b0;
        end
        if (latch_fall) begin
            next_sel = sel_now; // RQ7
            next_latched = 1'b1;
        end else if (strobe_fall && !latched) begin
            next_sel = sel_now; // RQ7
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            sel <= '0;
            latched <= 1'b0;
        end else if (clk_en_i) begin
            sel <= next_sel;
            latched <= next_latched;
        end
    end

    // =================================================================
    // Access state machine, ready and data bus.
    port_state_t state;
    port_state_t next_state;
    host_select_t sel_eff;
    logic is_read;
    logic needs_fetch;
    logic next_ready_n;
    logic next_oe;
    logic next_fetch_req;
    logic next_write_valid;
    logic [DATA_W-1:0] next_dout;
    logic [DATA_W-1:0] next_wdata;
    logic next_whalf;
    logic [1:0] next_wsel;

    // Selects valid on the strobe fall cycle come from the pins unless already latched.
    assign sel_eff = latched ? sel : sel_now;
    assign is_read = (sel_eff.read_write == `RW_READ);
    // Only the full word or the first half-word of a data register read fetches.
    assign needs_fetch = is_read && (sel_eff.access_select == `SEL_DATA_REG) && !sel_eff.halfword;

    always_comb begin
        next_state = state;
        next_ready_n = host_ready_n_o;
        next_oe = host_data_bus_oe_o;
        next_fetch_req = 1'b0;
        next_write_valid = 1'b0;
        next_dout = host_data_bus_o;
        next_wdata = write_data_o;
        next_whalf = write_halfword_o;
        next_wsel = write_select_o;
        case (state)
            ST_IDLE: begin
                if (strobe_fall) begin
                    if (is_read) begin
                        next_oe = 1'b1; // RQ9
                    end
                    if (needs_fetch) begin
                        next_fetch_req = 1'b1; // RQ3
                        next_ready_n = 1'b1; // RQ3
                        next_state = ST_FETCH;
                    end else if (is_read) begin
                        next_ready_n = 1'b0;
                        next_state = ST_READ;
                    end else begin
                        next_ready_n = ~write_buffer_ready_i; // RQ10
                        next_state = ST_WRITE;
                    end
                end
            end
            ST_FETCH: begin
                if (fetch_load_i) begin
                    next_dout = fetch_data_i;
                    next_ready_n = 1'b0; // RQ3
                    next_state = ST_READ;
                end
                if (strobe_rise) begin
                    next_oe = 1'b0; // RQ9
                    next_state = ST_IDLE;
                end
            end
            ST_READ: begin
                if (strobe_rise) begin
                    next_oe = 1'b0; // RQ9
                    next_state = ST_IDLE;
                end
            end
            ST_WRITE: begin
                next_ready_n = ~write_buffer_ready_i; // RQ10
                if (strobe_rise) begin
                    // Data is taken at the rising edge; selects come from the capture, as the pins may have moved.
                    next_wdata = host_data_bus_i; // RQ8
                    next_whalf = sel.halfword; // RQ7
                    next_wsel = sel.access_select; // RQ7
                    next_write_valid = 1'b1; // RQ8
                    next_ready_n = 1'b1;
                    next_state = ST_DONE;
                end
            end
            ST_DONE: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state <= ST_IDLE;
            host_ready_n_o <= 1'b1;
            host_data_bus_oe_o <= 1'b0;
            host_data_bus_o <= '0;
            fetch_req_o <= 1'b0;
            write_valid_o <= 1'b0;
            write_data_o <= '0;
            write_halfword_o <= 1'b0;
            write_select_o <= 2'h0;
        end else if (clk_en_i) begin
            state <= next_state;
            host_ready_n_o <= next_ready_n;
            host_data_bus_oe_o <= next_oe;
            host_data_bus_o <= next_dout;
            fetch_req_o <= next_fetch_req;
            write_valid_o <= next_write_valid;
            write_data_o <= next_wdata;
            write_halfword_o <= next_whalf;
            write_select_o <= next_wsel;
        end
    end

    // =================================================================
    // Checks.
    sequence fetch_start;
        clk_en_i && strobe_fall && needs_fetch && state == ST_IDLE;
    endsequence

    a_fetch_at_fall: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ3
        fetch_start |=> fetch_req_o && host_ready_n_o)
        else $error("Fetch not requested at strobe fall.");
    a_ready_until_load: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ3
        state == ST_FETCH && !fetch_load_i && !strobe_rise && clk_en_i |=> host_ready_n_o)
        else $error("Ready went low before fetch load.");
    a_drive_after_fall: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ9
        clk_en_i && state == ST_IDLE && strobe_fall && is_read |=> host_data_bus_oe_o)
        else $error("Read data not driven after strobe fall.");
    a_float_after_rise: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ9
        clk_en_i && strobe_rise && (state == ST_READ || state == ST_FETCH) |=> !host_data_bus_oe_o)
        else $error("Bus not released after strobe rise.");
    a_write_capture: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ8
        clk_en_i && state == ST_WRITE && strobe_rise |=> write_valid_o && write_data_o == $past(host_data_bus_i))
        else $error("Write data not captured at strobe rise.");
    a_write_ready: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ10
        clk_en_i && state == ST_WRITE && !strobe_rise |=> host_ready_n_o == $past(~write_buffer_ready_i))
        else $error("Write ready does not follow buffer state.");
    a_strobe_combine: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ1
        clk_en_i |=> strobe_q == $past(host_chip_select_i | ~(host_data_strobe_one_i ^ host_data_strobe_two_i)))
        else $error("Registered strobe does not follow the strobe equation.");
    a_select_latch: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ7
        clk_en_i && latch_fall |=> sel == $past(sel_now))
        else $error("Selects not captured at latch fall.");
    a_halfword_wide: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ2
        clk_en_i && !narrow_host_mode_i && (latch_fall || (strobe_fall && !latched)) |=> !sel.halfword)
        else $error("Halfword select captured in wide mode.");
endmodule

// ### testbench/dma_partner.sv
`timescale 1ns/100ps

// =====================================================================
// Fetch responder and write buffer standing behind the host port.
module dma_partner (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic fetch_req_i,
    input wire logic [3:0] delay_i,
    input wire logic [31:0] data_i,
    input wire logic stall_i,
    output logic fetch_load_o,
    output logic [31:0] fetch_data_o,
    output logic write_buffer_ready_o
);
    logic [3:0] count;

    // Each request restarts the countdown; the load pulse comes when it reaches one.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            count <= 4'h0;
        end else if (fetch_req_i) begin
            count <= delay_i;
        end else if (count != 4'h0) begin
            count <= count - 4'h1;
        end
    end

    // Outside the load pulse the data lines show the inverse, so stale data never matches.
    assign fetch_load_o = (count == 4'h1);
    assign fetch_data_o = fetch_load_o ? data_i : ~data_i;
    assign write_buffer_ready_o = !stall_i;
endmodule

// ### testbench/test_host_port_strobe_ready.sv
`timescale 1ns/100ps
`include "host_port_map.svh"

// =====================================================================
// Self-checking bench driving the host side at the falling clock edge.
module test_host_port_strobe_ready;
    import host_port_pkg::*;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic nar = 1'b0, cs = 1'b1, ds1 = 1'b0, ds2 = 1'b1, rw = 1'b1, hws = 1'b0, als = 1'b1, stall = 1'b0;
    logic [1:0] asel = 2'h0;
    logic [31:0] dbus = 32'h0000_0000, rdata = 32'h0000_0000;
    logic [3:0] delay = 4'h1;
    logic [31:0] data_o, fdata, wdata;
    logic oe, ready_n, freq, fload, wvalid, whalf, bufrdy;
    logic [1:0] wsel;
    logic en = 1'b1;
    int seed, n_errors, checks_done, n_fetch, n_wv, cyc, k;

    host_port_strobe_ready #(.DATA_W(32)) i_host_port_strobe_ready (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .clk_en_i(en), .narrow_host_mode_i(nar), .host_chip_select_i(cs), .host_data_strobe_one_i(ds1),
        .host_data_strobe_two_i(ds2), .host_access_select_i(asel), .host_read_write_i(rw),
        .halfword_select_i(hws), .host_address_latch_strobe_i(als), .host_data_bus_i(dbus),
        .host_data_bus_o(data_o), .host_data_bus_oe_o(oe), .host_ready_n_o(ready_n), .fetch_req_o(freq),
        .fetch_load_i(fload), .fetch_data_i(fdata), .write_valid_o(wvalid), .write_data_o(wdata),
        .write_halfword_o(whalf), .write_select_o(wsel), .write_buffer_ready_i(bufrdy));

    dma_partner i_dma_partner (.clock_i(clock_i), .rst_n_i(rst_n_i), .fetch_req_i(freq), .delay_i(delay),
        .data_i(rdata), .stall_i(stall), .fetch_load_o(fload), .fetch_data_o(fdata),
        .write_buffer_ready_o(bufrdy));

    always #5 clock_i = ~clock_i;

    // Pulse counters and the hang limit; a whole run needs well under a thousand cycles.
    always @(posedge clock_i) begin
        cyc++;
        if (freq === 1'b1) n_fetch++;
        if (wvalid === 1'b1) n_wv++;
        if (cyc > 5000) begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (exp !== got) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic print_verdict();
        if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Only a data register read fetches, and in narrow mode only its first half-word.
    function automatic int exp_fetch(logic rd, logic [1:0] sel, logic hw, logic nr);
        return (rd == `RW_READ && sel == `SEL_DATA_REG && !(nr && hw)) ? 1 : 0;
    endfunction

    // One host access; with the latch in use the pins carry garbage by the time the strobe falls.
    task automatic access(input logic rd, input logic [1:0] sel, input logic hw, input logic nr,
                          input logic lat, input logic stl);
        int f0, w0, n;
        logic [31:0] wd;
        f0 = n_fetch;
        w0 = n_wv;
        wd = $random(seed);
        rdata = $random(seed);
        delay = 4'h1 + 4'($unsigned($random(seed)) % 8);
        @(negedge clock_i);
        chk("oe idle", 0, oe);
        nar = nr;
        asel = sel;
        hws = hw;
        rw = rd;
        stall = stl && !rd;
        als = !lat;
        @(negedge clock_i);
        if (lat) {asel, rw, hws} = ~{sel, rd, hw};
        cs = 1'b0;
        ds2 = ~ds1;
        dbus = wd;
        // The first pass always waits, since ready_n may still stand low from the previous read.
        for (n = 0; n < 40 && (n == 0 || ready_n !== 1'b0); n++) begin
            @(negedge clock_i);
            als = 1'b1;
            if (n == 0) {asel, rw, hws} = ~{sel, rd, hw};
            if (n == 3 && stall) begin
                chk("ready_n while full", 1, ready_n);
                stall = 1'b0;
            end
        end
        chk("ready_n", 0, ready_n);
        repeat (`STROBE_LOW_CYC) @(negedge clock_i);
        chk("oe read", rd == `RW_READ, oe);
        if (exp_fetch(rd, sel, hw, nr) == 1) chk("read data", rdata, data_o);
        ds2 = ds1;
        cs = 1'b1;
        @(negedge clock_i);
        @(negedge clock_i);
        dbus = ~wd;
        chk("oe after rise", 0, oe);
        chk("fetch count", exp_fetch(rd, sel, hw, nr), n_fetch - f0);
        chk("write count", rd != `RW_READ, n_wv - w0);
        if (rd != `RW_READ) begin
            chk("write data", wd, wdata);
            chk("write select", sel, wsel);
            chk("write half", nr && hw, whalf);
        end
        repeat (`STROBE_HIGH_PERIODS) @(negedge clock_i);
    endtask

    // Main sequence: refused strobe forms, hand corner cases, then random accesses.
    initial begin
        seed = 58164;
        repeat (10) @(negedge clock_i);
        rst_n_i = 1'b1;
        @(negedge clock_i);
        chk("ready_n reset", 1, ready_n);
        // Chip select low with equal strobes, then differing strobes with chip select high: no access.
        for (k = 0; k < 2; k++) begin
            asel = `SEL_DATA_REG;
            cs = k[0];
            ds2 = k[0] ? ~ds1 : ds1;
            repeat (8) @(negedge clock_i);
            chk("ready_n no strobe", 1, ready_n);
            chk("fetch no strobe", 0, n_fetch);
            cs = 1'b1;
            ds1 = ~ds1;
            @(negedge clock_i);
        end
        // A real read strobe while the clock enable is low must leave all state untouched.
        en = 1'b0;
        cs = 1'b0;
        ds2 = ~ds1;
        repeat (8) @(negedge clock_i);
        chk("fetch frozen", 0, n_fetch);
        chk("ready_n frozen", 1, ready_n);
        cs = 1'b1;
        ds2 = ds1;
        @(negedge clock_i);
        en = 1'b1;
        access(1'b1, `SEL_DATA_REG, 1'b0, 1'b0, 1'b1, 1'b0);
        access(1'b1, `SEL_DATA_REG, 1'b1, 1'b1, 1'b0, 1'b0);
        access(1'b0, `SEL_DATA_REG, 1'b1, 1'b1, 1'b1, 1'b1);
        access(1'b0, 2'h1, 1'b0, 1'b0, 1'b0, 1'b1);
        for (k = 0; k < 16; k++) begin
            access(1'($random(seed)), 2'($random(seed)), 1'($random(seed)),
                   1'($random(seed)), 1'($random(seed)), 1'($random(seed)));
        end
        print_verdict();
    end
endmodule
